/* ast_map.vh */
// Purpose: Register offsets, field positions and timing constants of the serial transceiver
// Assumes: Plain register port with an 8-bit data path
// Notes:   Offsets are register indices on the plain port
`ifndef AST_MAP_VH
`define AST_MAP_VH

// Register offsets
`define AST_ADDR_W        3
`define AST_OFF_DATA      3'h0
`define AST_OFF_CTRL      3'h1
`define AST_OFF_DIV_LO    3'h2
`define AST_OFF_DIV_HI    3'h3
`define AST_OFF_MATCH     3'h4
`define AST_OFF_MASK      3'h5
`define AST_OFF_FLAGS     3'h6

// Control write fields
`define AST_CW_WORD8      0
`define AST_CW_PAR_EN     1
`define AST_CW_ODD        2
`define AST_CW_STOP2      3

// Status read fields
`define AST_ST_TRANSMITTER_BUSY      0
`define AST_ST_FULL       1
`define AST_ST_EMPTY      2
`define AST_ST_CHECK_BIT_ERROR       3
`define AST_ST_BUFFER_OVERFLOW       4
`define AST_ST_FRAMING_ERROR       5
`define AST_ST_LINE_BREAK_SEEN       6
`define AST_ST_RECEIVER_BUSY      7

// Event mask and flag fields
`define AST_EV_RECEIVE_COMPLETE_EVENT       0
`define AST_EV_BRK        1
`define AST_EV_ADR        2

// Timing
`define AST_DIV_W         13
`define AST_SMP_PER_BIT   4'h8
`define AST_SMP_TAKE      4'h4
`define AST_SMP_LAST      4'h7
`define AST_QUARTER_SMP   4'h2
`define AST_CFG_RESET     4'h0
`define AST_DIV_RESET     13'h0000

`endif

/* ast_transceiver.v */
// Purpose: Asynchronous serial transmitter and receiver with a two-entry receive buffer
// Assumes: Divider written nonzero by software before use, transmit written only when idle
// Notes:   Sample tick = clock/(divider+1); one bit spans eight sample ticks
//
// What this block does
// - Pulse the interrupt output whenever transmitter busy falls; no flag, no mask.
// - Receive-complete event at every telegram end, even when full; masked to interrupt.
// - Break and match events reach interrupt when masked in; they then set flags.
// - Receive flag set only when the buffer was empty before that completion.
// - Interrupt pulses at most once per telegram, whatever events coincide.
// - Event flags hold until the end of the next telegram or break, then update.
// - No match event nor flag when parity or frame error occurred.
// - Data write loads shifter, starts start bit, sets transmitter busy.
// - At nominal end of last stop bit clear busy and pulse interrupt.
// - First falling receive edge starts reception and sets receiver busy.
// - After last bit push data and status, raise event, clear receiver busy.
// - Parity error set when received parity differs from configured parity.
// - Frame error set when start or stop bit level is wrong.
// - Break flagged when input low for a whole telegram length.
// - After a break, receive needs line high a quarter bit first.
// - Two entries; full on second; third telegram discarded, overrun set.
// - Data read pops oldest entry; visible error flags follow next entry.
// - Clearing module enable aborts traffic and resets all internal registers.
// - Two-of-three majority filter at sample rate; bit taken on fifth sample.
// - New reception may start right after final stop sample; flags set then.
// - Control bits select word size, parity enable, odd parity, two stops.
// - Sample rate is clock over divider plus one; bit rate sample over eight.
// - Start bit driven opposite idle level; stop bits at idle level.
// - Parity bit makes ones count of data plus parity odd or even.
// - Each received word compared with match value; equality raises match event.
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "ast_map.vh"

module ast_transceiver (
	// Clock and reset
	input  wire       clock,
	input  wire       rst_n,
	// Module enable, low holds everything in reset
	input  wire       module_enable,
	// Register port
	input  wire [2:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata,
	// Serial lines
	input  wire       serial_rx,
	output reg        serial_tx,
	// Interrupt source
	output reg        irq_pulse
);

	// Control and configuration
	reg [3:0]  cfg_r;
	reg [12:0] div_r;
	reg [7:0]  match_r;
	reg [2:0]  mask_r;
	reg [2:0]  flags_r;
	reg        buffer_overflow_r;
	reg        line_break_seen_pend_r;

	// Sample rate generator
	reg [12:0] div_cnt_r;
	reg        tick_r;

	// Receive filter and frame
	reg [2:0]  rx_hist_r;
	reg        rx_filt_r;
	reg        receiver_busy_r;
	reg [2:0]  rx_smp_r;
	reg [3:0]  rx_bit_r;
	reg [10:0] rx_shift_r;
	reg        rx_fr_r;

	// Break detection and recovery
	reg [6:0]  brk_cnt_r;
	reg        brk_hold_r;
	reg [3:0]  hi_cnt_r;

	// Receive buffer: data plus parity, frame and break status
	reg [10:0] fifo_mem_r [0:1];
	reg [1:0]  fifo_cnt_r;
	reg        fifo_rp_r;

	// Transmitter
	reg        transmitter_busy_r;
	reg [2:0]  tx_smp_r;
	reg [3:0]  tx_bit_r;
	reg [11:0] tx_shift_r;

	// Telegram length in bits from the format bits
	function [3:0] tg_len;
		input [3:0] cfg;
		begin
			tg_len = 4'h9 + {3'h0, cfg[`AST_CW_WORD8]} + {3'h0, cfg[`AST_CW_PAR_EN]}
				+ {3'h0, cfg[`AST_CW_STOP2]};
		end
	endfunction

	wire       rst_all   = ~rst_n;
	wire       en        = module_enable;
	wire [3:0] len       = tg_len(cfg_r);
	wire       word8     = cfg_r[`AST_CW_WORD8];
	wire       par_en    = cfg_r[`AST_CW_PAR_EN];
	wire       odd       = cfg_r[`AST_CW_ODD];
	wire       wr_data   = reg_wr && reg_addr == `AST_OFF_DATA;
	wire       rd_data   = reg_rd && reg_addr == `AST_OFF_DATA;
	wire       fifo_empty = fifo_cnt_r == 2'h0;
	wire       fifo_full  = fifo_cnt_r == 2'h2;
	wire [10:0] head     = fifo_mem_r[fifo_rp_r];

	// Majority of three raw line samples
	wire maj = (rx_hist_r[0] & rx_hist_r[1]) | (rx_hist_r[1] & rx_hist_r[2])
		| (rx_hist_r[0] & rx_hist_r[2]);

	// Received telegram decode: bits stored LSB first from start bit onward
	reg  [7:0] rx_word;
	reg        rx_par;
	reg        rx_stop_ok;
	reg        rx_ones;
	always @* begin
		rx_word    = word8 ? rx_shift_r[8:1] : {1'b0, rx_shift_r[7:1]};
		rx_par     = word8 ? rx_shift_r[9] : rx_shift_r[8];
		rx_ones    = ^rx_word ^ (par_en ? rx_par : 1'b0);
		// Final stop is the live sample, not yet stored in the shifter
		// With two stops the first one sits just below it in every format
		rx_stop_ok = rx_filt_r & (cfg_r[`AST_CW_STOP2] ? rx_shift_r[len - 4'h2] : 1'b1);
	end

	// Final sample of a telegram
	wire rx_take  = receiver_busy_r && tick_r && rx_smp_r == `AST_SMP_TAKE;
	wire rx_last  = rx_take && rx_bit_r == len - 4'h1;
	wire par_err  = par_en && (rx_ones != odd);
	wire fr_err   = rx_fr_r || !rx_stop_ok;
	wire match_ev = (rx_word == match_r) && !par_err && !fr_err;
	wire brk_ev   = tick_r && !rx_filt_r && !brk_hold_r
		&& brk_cnt_r == {len, 3'h0} - 7'h1;
	wire tx_done  = transmitter_busy_r && tick_r && tx_smp_r == `AST_SMP_LAST
		&& tx_bit_r == len - 4'h1;

	// Sample rate generator, down counter reloaded with divider
	// A zero divider ticks every clock; software must load 1 or more
	// Divider changes only take effect at the next reload, so a
	// half-written value lasts at most one sample period
	always @(posedge clock or posedge rst_all) begin
		if (rst_all) begin
			div_cnt_r <= `AST_DIV_RESET;
			tick_r    <= 1'b0;
		end else if (!en) begin
			div_cnt_r <= `AST_DIV_RESET;
			tick_r    <= 1'b0;
		end else begin
			tick_r    <= div_cnt_r == `AST_DIV_RESET;
			div_cnt_r <= (div_cnt_r == `AST_DIV_RESET) ? div_r : div_cnt_r - 13'h0001;
		end
	end

	// Register writes; divider high byte written last completes the value
	always @(posedge clock or posedge rst_all) begin
		if (rst_all) begin
			cfg_r   <= `AST_CFG_RESET;
			div_r   <= `AST_DIV_RESET;
			match_r <= 8'h00;
			mask_r  <= 3'h0;
		end else if (!en) begin
			cfg_r   <= `AST_CFG_RESET;
			div_r   <= `AST_DIV_RESET;
			match_r <= 8'h00;
			mask_r  <= 3'h0;
		end else if (reg_wr) begin
			case (reg_addr)
			`AST_OFF_CTRL:   cfg_r <= reg_wdata[3:0];
			`AST_OFF_DIV_LO: div_r[7:0] <= reg_wdata;
			`AST_OFF_DIV_HI: div_r[12:8] <= reg_wdata[4:0];
			`AST_OFF_MATCH:  match_r <= reg_wdata;
			`AST_OFF_MASK:   mask_r <= reg_wdata[2:0];
			default: ;
			endcase
		end
	end

	// Transmitter: start, data, parity, stops shifted out LSB first
	always @(posedge clock or posedge rst_all) begin
		if (rst_all) begin
			transmitter_busy_r    <= 1'b0;
			tx_smp_r   <= 3'h0;
			tx_bit_r   <= 4'h0;
			tx_shift_r <= 12'hFFF;
			serial_tx  <= 1'b1;
		end else if (!en) begin
			transmitter_busy_r    <= 1'b0;
			tx_smp_r   <= 3'h0;
			tx_bit_r   <= 4'h0;
			tx_shift_r <= 12'hFFF;
			serial_tx  <= 1'b1;
		end else if (wr_data) begin
			transmitter_busy_r  <= 1'b1;
			tx_smp_r <= 3'h0;
			tx_bit_r <= 4'h0;
			serial_tx <= 1'b0;
			if (word8)
				tx_shift_r <= {2'h3, ^reg_wdata ^ odd | ~par_en, reg_wdata, 1'b0};
			else if (par_en)
				tx_shift_r <= {3'h7, ^reg_wdata[6:0] ^ odd, reg_wdata[6:0], 1'b0};
			else
				tx_shift_r <= {4'hF, reg_wdata[6:0], 1'b0};
		end else if (transmitter_busy_r && tick_r) begin
			tx_smp_r <= tx_smp_r + 3'h1;
			if (tx_smp_r == `AST_SMP_LAST) begin
				if (tx_done) begin
					transmitter_busy_r   <= 1'b0;
					serial_tx <= 1'b1;
				end else begin
					tx_bit_r   <= tx_bit_r + 4'h1;
					tx_shift_r <= {1'b1, tx_shift_r[11:1]};
					serial_tx  <= tx_shift_r[1];
				end
			end
		end
	end

	// Receiver filter, framing, break watch
	always @(posedge clock or posedge rst_all) begin
		if (rst_all) begin
			rx_hist_r   <= 3'h7;
			rx_filt_r   <= 1'b1;
			receiver_busy_r     <= 1'b0;
			rx_smp_r    <= 3'h0;
			rx_bit_r    <= 4'h0;
			rx_shift_r  <= 11'h000;
			rx_fr_r     <= 1'b0;
			brk_cnt_r   <= 7'h00;
			brk_hold_r  <= 1'b0;
			hi_cnt_r    <= 4'h0;
		end else if (!en) begin
			rx_hist_r   <= 3'h7;
			rx_filt_r   <= 1'b1;
			receiver_busy_r     <= 1'b0;
			rx_smp_r    <= 3'h0;
			rx_bit_r    <= 4'h0;
			rx_shift_r  <= 11'h000;
			rx_fr_r     <= 1'b0;
			brk_cnt_r   <= 7'h00;
			brk_hold_r  <= 1'b0;
			hi_cnt_r    <= 4'h0;
		end else if (tick_r) begin
			rx_hist_r <= {rx_hist_r[1:0], serial_rx};
			rx_filt_r <= maj;
			// Break timer counts low samples, a high sample restarts it
			if (rx_filt_r)
				brk_cnt_r <= 7'h00;
			else if (!brk_ev && !brk_hold_r)
				brk_cnt_r <= brk_cnt_r + 7'h01;
			if (brk_ev)
				brk_hold_r <= 1'b1;
			// Recovery needs a quarter bit of high before new reception
			if (brk_hold_r) begin
				hi_cnt_r <= rx_filt_r ? hi_cnt_r + 4'h1 : 4'h0;
				if (rx_filt_r && hi_cnt_r == `AST_QUARTER_SMP - 4'h1) begin
					brk_hold_r <= 1'b0;
					hi_cnt_r   <= 4'h0;
				end
			end
			if (!receiver_busy_r) begin
				if (rx_filt_r && !maj && !brk_hold_r) begin
					receiver_busy_r  <= 1'b1;
					rx_smp_r <= 3'h1;
					rx_bit_r <= 4'h0;
					rx_fr_r  <= 1'b0;
				end
			end else begin
				rx_smp_r <= rx_smp_r + 3'h1;
				if (rx_smp_r == `AST_SMP_TAKE) begin
					rx_shift_r[rx_bit_r] <= rx_filt_r;
					if (rx_bit_r == 4'h0 && rx_filt_r)
						rx_fr_r <= 1'b1;
					rx_bit_r <= rx_bit_r + 4'h1;
					if (rx_last)
						receiver_busy_r <= 1'b0;
				end
			end
		end
	end

	// Receive buffer push and pop; a break also makes an entry
	// Write slot is the one after the newest entry; when full and read in the
	// same cycle, the slot being popped takes the new entry, so no
	// telegram is lost to a read that races the stop sample
	// Overrun stays set until disable, as nothing else clears it
	wire push = rx_last || brk_ev;
	wire [10:0] push_ent = brk_ev ? {1'b1, 2'h0, 8'h00}
		: {1'b0, fr_err, par_err, rx_word};
	always @(posedge clock or posedge rst_all) begin
		if (rst_all) begin
			fifo_cnt_r    <= 2'h0;
			fifo_rp_r     <= 1'b0;
			buffer_overflow_r        <= 1'b0;
			fifo_mem_r[0] <= 11'h000;
			fifo_mem_r[1] <= 11'h000;
		end else if (!en) begin
			fifo_cnt_r    <= 2'h0;
			fifo_rp_r     <= 1'b0;
			buffer_overflow_r        <= 1'b0;
			fifo_mem_r[0] <= 11'h000;
			fifo_mem_r[1] <= 11'h000;
		end else begin
			if (rd_data && !fifo_empty)
				fifo_rp_r <= ~fifo_rp_r;
			if (push && (!fifo_full || rd_data))
				fifo_mem_r[fifo_rp_r ^ fifo_cnt_r[0]] <= push_ent;
			else if (push)
				buffer_overflow_r <= 1'b1;
			case ({push && (!fifo_full || rd_data), rd_data && !fifo_empty})
			2'b10:   fifo_cnt_r <= fifo_cnt_r + 2'h1;
			2'b01:   fifo_cnt_r <= fifo_cnt_r - 2'h1;
			default: fifo_cnt_r <= fifo_cnt_r;
			endcase
		end
	end

	// Event flags refreshed at each telegram end, single interrupt pulse
	// Flags are replaced as a whole at every push, so software sees
	// only the events of the latest telegram or break
	// Transmit end and receive end can meet in one cycle; they share
	// the pulse then, which the interrupt controller cannot split
	wire [2:0] ev_now = {match_ev & rx_last & mask_r[`AST_EV_ADR],
		brk_ev & mask_r[`AST_EV_BRK],
		rx_last & fifo_empty & mask_r[`AST_EV_RECEIVE_COMPLETE_EVENT]};
	wire rx_irq = (rx_last && mask_r[`AST_EV_RECEIVE_COMPLETE_EVENT]) || ev_now[2] || ev_now[1];
	always @(posedge clock or posedge rst_all) begin
		if (rst_all) begin
			flags_r     <= 3'h0;
			irq_pulse   <= 1'b0;
			line_break_seen_pend_r <= 1'b0;
		end else if (!en) begin
			flags_r     <= 3'h0;
			irq_pulse   <= 1'b0;
			line_break_seen_pend_r <= 1'b0;
		end else begin
			if (push)
				flags_r <= ev_now;
			line_break_seen_pend_r <= brk_ev;
			// One pulse covers all events of the telegram
			irq_pulse <= rx_irq || tx_done;
		end
	end

	// Read data, one cycle after the strobe
	// Held at zero outside that cycle so a wired read bus stays quiet
	always @(posedge clock or posedge rst_all) begin
		if (rst_all) begin
			reg_rdata <= 8'h00;
		end else if (!en || !reg_rd) begin
			reg_rdata <= 8'h00;
		end else begin
			case (reg_addr)
			`AST_OFF_DATA:  reg_rdata <= head[7:0];
			`AST_OFF_CTRL:  reg_rdata <= {receiver_busy_r, head[10] & ~fifo_empty,
				head[9] & ~fifo_empty, buffer_overflow_r, head[8] & ~fifo_empty,
				fifo_empty, fifo_full, transmitter_busy_r};
			`AST_OFF_FLAGS: reg_rdata <= {5'h00, flags_r};
			default:        reg_rdata <= 8'h00;
			endcase
		end
	end

endmodule

/* ast_transceiver_props.sv */
// Purpose: Port-level checks of the serial transceiver
// Assumes: Divider of at least 1, so one bit spans 16 clocks or more
// Notes:   Bound to every transceiver instance
`timescale 1ns/1ps
`include "ast_map.vh"
module ast_transceiver_props (
	// Clock and reset
	input wire       clock,
	input wire       rst_n,
	input wire       module_enable,
	// Register port
	input wire [2:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_wr,
	input wire       reg_rd,
	input wire [7:0] reg_rdata,
	// Serial lines and interrupt
	input wire       serial_rx,
	input wire       serial_tx,
	input wire       irq_pulse
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Bus steps used by the busy check
	sequence s_tx_wr;
		reg_wr && module_enable && reg_addr == `AST_OFF_DATA;
	endsequence
	sequence s_st_rd;
		reg_rd && reg_addr == `AST_OFF_CTRL;
	endsequence
	// Interrupt shape
	property p_irq_pulse; irq_pulse |=> !irq_pulse; endproperty
	property p_irq_once; $rose(irq_pulse) |-> ##2 (!irq_pulse)[*8]; endproperty
	// Transmit start and busy
	property p_tx_start; s_tx_wr |=> !serial_tx; endproperty
	property p_tx_busy; s_tx_wr ##2 s_st_rd |=> reg_rdata[`AST_ST_TRANSMITTER_BUSY]; endproperty
	// No level on the line shorter than eight clocks, half the shortest bit, aborts excepted
	property p_low_len; $fell(serial_tx) |-> (!serial_tx || !module_enable)[*8]; endproperty
	property p_high_len;
		$rose(serial_tx) && module_enable |-> (serial_tx || !module_enable)[*8];
	endproperty
	// Disable forces the line idle and silences the interrupt
	property p_abort; !module_enable |=> serial_tx && !irq_pulse; endproperty
	// Read data only in the cycle after a read
	property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than a cycle");
	a_irq_once: assert property (p_irq_once) else $error("irq repeated too soon");
	a_tx_start: assert property (p_tx_start) else $error("no start bit");
	a_tx_busy: assert property (p_tx_busy) else $error("busy not set");
	a_low_len: assert property (p_low_len) else $error("low level too short");
	a_high_len: assert property (p_high_len) else $error("high level too short");
	a_abort: assert property (p_abort) else $error("disable did not abort");
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
endmodule
bind ast_transceiver ast_transceiver_props i_ast_transceiver_props (
	.clock(clock), .rst_n(rst_n), .module_enable(module_enable),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_rx(serial_rx),
	.serial_tx(serial_tx), .irq_pulse(irq_pulse));

/* ast_serial_partner.sv */
// Purpose: Far-end serial station feeding the receive line and watching transmit
// Assumes: Bit time fixed by the bench to match the divider
// Notes:   Frame bits come whole from the caller, bad ones included
`timescale 1ns/1ps
module ast_serial_partner #(parameter int BIT = 16) (
	// Clock
	input wire    clock,
	// Lines
	input wire    serial_tx,
	output logic  serial_rx
);
	logic [7:0] got;
	// Idle high, as a pulled-up line rests
	initial serial_rx = 1'b1;
	// Send bits LSB first, each held one bit time
	task automatic send(input logic [11:0] f, input int n);
		@(posedge clock);
		for (int i = 0; i < n; i++) begin
			serial_rx <= f[i];
			repeat (BIT) @(posedge clock);
		end
		serial_rx <= 1'b1;
	endtask
	// Mid-bit sampling; data zeros cannot retrigger inside the loop
	initial forever begin
		@(negedge serial_tx);
		repeat (BIT / 2) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge clock);
			got[i] = serial_tx;
		end
		repeat (BIT) @(posedge clock);
	end
endmodule

/* ast_transceiver_tb_top.sv */
// Purpose: Self-checking bench of the serial transceiver
// Assumes: Divider 1, so one bit is 16 clocks
// Notes:   Never transmits while receiving, keeping interrupts apart
`timescale 1ns/1ps
`include "ast_map.vh"
module ast_transceiver_tb_top;
	localparam int BIT = 16;
	logic       clock = 1'b0;
	logic       rst_n = 1'b0;
	logic       module_enable = 1'b1;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	wire  [7:0] reg_rdata;
	wire        serial_rx;
	wire        serial_tx;
	wire        irq_pulse;
	int         n_errors = 0;
	int         check_count = 0;
	int         cycles = 0;
	int         c;
	logic [7:0] q;
	ast_transceiver i_ast_transceiver (.clock(clock), .rst_n(rst_n),
		.module_enable(module_enable), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.serial_rx(serial_rx), .serial_tx(serial_tx), .irq_pulse(irq_pulse));
	ast_serial_partner #(.BIT(BIT)) i_ast_serial_partner (.clock(clock),
		.serial_tx(serial_tx), .serial_rx(serial_rx));
	initial forever #12.5 clock = ~clock;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One access; read data taken in the cycle after the strobe
	task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1 q = reg_rdata;
	endtask
	task automatic stat(input logic [7:0] m, input logic [7:0] e);
		acc(1'b0, `AST_OFF_CTRL, 8'h00);
		chk(q & m, e);
	endtask
	// Bounded wait; the pulse lasts one cycle so look after each edge
	task automatic wirq;
		c = 0;
		while (irq_pulse !== 1'b1 && c < 400) begin
			@(posedge clock);
			#1 c++;
		end
	endtask
	task automatic frame(input logic [11:0] f, input int n);
		fork
			i_ast_serial_partner.send(f, n);
			wirq();
		join
	endtask
	task automatic t_reset;
		stat(8'h97, 8'h04);
		acc(1'b0, 3'h7, 8'h00);
		chk(q, 8'h00);
	endtask
	task automatic t_tx;
		acc(1'b1, `AST_OFF_CTRL, 8'h01);
		acc(1'b1, `AST_OFF_DIV_LO, 8'h01);
		acc(1'b1, `AST_OFF_DIV_HI, 8'h00);
		acc(1'b1, `AST_OFF_DATA, 8'hA5);
		stat(8'h01, 8'h01);
		wirq();
		chk(8'(c >= 150 && c <= 166), 8'h01);
		chk(i_ast_serial_partner.got, 8'hA5);
		stat(8'h01, 8'h00);
	endtask
	task automatic t_rx;
		acc(1'b1, `AST_OFF_MASK, 8'h01);
		frame({1'b1, 8'h3C, 1'b0}, 10);
		chk(8'(c < 400), 8'h01);
		acc(1'b0, `AST_OFF_FLAGS, 8'h00);
		chk(q & 8'h07, 8'h01);
		frame({1'b1, 8'h5A, 1'b0}, 10);
		stat(8'h16, 8'h02);
		acc(1'b0, `AST_OFF_FLAGS, 8'h00);
		chk(q & 8'h07, 8'h00);
		frame({1'b1, 8'h11, 1'b0}, 10);
		chk(8'(c < 400), 8'h01);
		stat(8'h16, 8'h12);
		acc(1'b0, `AST_OFF_DATA, 8'h00);
		chk(q, 8'h3C);
		acc(1'b0, `AST_OFF_DATA, 8'h00);
		chk(q, 8'h5A);
		stat(8'h06, 8'h04);
	endtask
	task automatic t_err;
		acc(1'b1, `AST_OFF_CTRL, 8'h03);
		acc(1'b1, `AST_OFF_MATCH, 8'h3C);
		acc(1'b1, `AST_OFF_MASK, 8'h05);
		frame({1'b1, ^8'h3C, 8'h3C, 1'b0}, 11);
		acc(1'b0, `AST_OFF_FLAGS, 8'h00);
		chk(q & 8'h07, 8'h05);
		stat(8'h28, 8'h00);
		acc(1'b0, `AST_OFF_DATA, 8'h00);
		frame({1'b1, ~^8'h3C, 8'h3C, 1'b0}, 11);
		stat(8'h08, 8'h08);
		acc(1'b0, `AST_OFF_FLAGS, 8'h00);
		chk(q & 8'h07, 8'h01);
		acc(1'b0, `AST_OFF_DATA, 8'h00);
		frame({1'b0, ^8'h3C, 8'h3C, 1'b0}, 11);
		stat(8'h20, 8'h20);
	endtask
	// Long low line: errored telegram then break entry, break flag only
	task automatic t_brk;
		acc(1'b0, `AST_OFF_DATA, 8'h00);
		acc(1'b1, `AST_OFF_MASK, 8'h02);
		frame(12'h000, 12);
		chk(8'(c < 400), 8'h01);
		acc(1'b0, `AST_OFF_FLAGS, 8'h00);
		chk(q & 8'h07, 8'h02);
		acc(1'b0, `AST_OFF_DATA, 8'h00);
		stat(8'h40, 8'h40);
	endtask
	// Disable in mid-transmit clears the entry and overrun left behind
	task automatic t_abort;
		acc(1'b1, `AST_OFF_DATA, 8'h00);
		repeat (40) @(posedge clock);
		module_enable <= 1'b0;
		repeat (10) @(posedge clock);
		chk(8'(serial_tx), 8'h01);
		module_enable <= 1'b1;
		stat(8'h97, 8'h04);
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Hang guard, far above the 1500 or so cycles needed
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			end_of_test();
		end
	end
	initial begin
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		t_reset();
		t_tx();
		t_rx();
		t_err();
		t_brk();
		t_abort();
		end_of_test();
	end
endmodule
